// File: hw/data_op_unit.sv
`timescale 1ns/100ps
// Functional notes
// - compare input against references at 16 or 32 bits, six test kinds
// - add or subtract operands at the selected 16 or 32 bit width
// - control bits 6:4 select the test; codes above 101 are prohibited
// - code 100 detects reference 0 < input < reference 1
// - code 101 detects input below reference 0 or above reference 1
// - detection raises an interrupt when the enable bit is set
// - addition beyond the active width flags overflow
// - subtraction below zero flags underflow
// - event output pulses on detection, overflow and underflow
// - control bit 7 enables and gates the interrupt request
// - the operand input register is 32 bits wide
// - one size bit picks 16 bit (0) or 32 bit (1) for all operations
// - status register keeps results; a clear register clears them
// - two reference registers: single bound, or lower and upper bound
// - module stop halts all operation until released
module data_op_unit #(
	parameter int DATA_W = 32
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [data_op_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [data_op_pkg::ADDR_W-1:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic irq_o,
	output logic event_o
);
	// ****************************************************************
	// width check
	// ****************************************************************
	if (DATA_W != 32) begin : g_bad_width
		$error("data_op_unit: the bus map serves DATA_W of 32 only");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	logic aw_full_r, aw_full_nxt;
	logic [data_op_pkg::ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
	logic w_full_r, w_full_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [31:0] input_r, input_nxt;
	logic [31:0] ref0_r, ref0_nxt;
	logic [31:0] ref1_r, ref1_nxt;
	logic [2:0] status_r, status_nxt;
	logic stop_r, stop_nxt;
	logic eval_r, eval_nxt;
	logic event_r, event_nxt;

	logic do_write;
	logic addr_ok_w;
	logic addr_ok_r;
	logic [1:0] op_sel;
	logic size_32;
	logic detect_w;
	logic [DATA_W-1:0] arith_result;
	logic arith_wrap;
	logic [2:0] status_set;
	logic [2:0] status_clr;

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// address decode
	function automatic logic mapped(input logic [data_op_pkg::ADDR_W-1:0] addr);
		return addr == data_op_pkg::OFS_CTRL || addr == data_op_pkg::OFS_STATUS ||
			addr == data_op_pkg::OFS_STATUS_CLEAR || addr == data_op_pkg::OFS_INPUT ||
			addr == data_op_pkg::OFS_REF0 || addr == data_op_pkg::OFS_REF1 ||
			addr == data_op_pkg::OFS_POWER;
	endfunction

	// ****************************************************************
	// operation units
	// ****************************************************************
	assign op_sel = ctrl_r[data_op_pkg::CTRL_OP_LSB +: 2];
	assign size_32 = ctrl_r[data_op_pkg::CTRL_SIZE_BIT];

	data_op_compare #(.DATA_W(DATA_W)) u_compare (
		.operand_i(input_r),
		.ref0_i(ref0_r),
		.ref1_i(ref1_r),
		.size_32_i(size_32),
		.detect_sel_i(ctrl_r[data_op_pkg::CTRL_DETECT_CONDITION_SELECT_LSB +: 3]),
		.detect_o(detect_w)
	);

	data_op_arith #(.DATA_W(DATA_W)) u_arith (
		.operand_i(input_r),
		.accum_i(ref0_r),
		.size_32_i(size_32),
		.subtract_i(op_sel == data_op_pkg::OP_SUB),
		.result_o(arith_result),
		.wrap_o(arith_wrap)
	);

	// ****************************************************************
	// bus handshakes
	// ****************************************************************
	assign s_axi_awready_o = !aw_full_r;
	assign s_axi_wready_o = !w_full_r;
	assign s_axi_arready_o = !rvalid_r;
	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o = rdata_r;
	assign s_axi_rresp_o = rresp_r;
	assign do_write = aw_full_r && w_full_r && !bvalid_r;
	assign addr_ok_w = mapped(aw_addr_r);
	assign addr_ok_r = mapped(s_axi_araddr_i);

	// write channel capture and response
	always_comb begin
		aw_full_nxt = aw_full_r;
		aw_addr_nxt = aw_addr_r;
		w_full_nxt = w_full_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid_i && !aw_full_r) begin
			aw_full_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !w_full_r) begin
			w_full_nxt = 1'b1;
			w_data_nxt = s_axi_wdata_i;
			w_strb_nxt = s_axi_wstrb_i;
		end
		if (do_write) begin
			aw_full_nxt = 1'b0;
			w_full_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = addr_ok_w ? data_op_pkg::RESP_OKAY : data_op_pkg::RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready_i) begin
			bvalid_nxt = 1'b0;
		end
	end

	// read channel, data registered at acceptance
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid_i && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = addr_ok_r ? data_op_pkg::RESP_OKAY : data_op_pkg::RESP_SLVERR;
			case (s_axi_araddr_i)
				data_op_pkg::OFS_CTRL: rdata_nxt = {24'h00_0000, ctrl_r};
				data_op_pkg::OFS_STATUS: rdata_nxt = {29'h0000_0000, status_r};
				data_op_pkg::OFS_INPUT: rdata_nxt = input_r;
				data_op_pkg::OFS_REF0: rdata_nxt = ref0_r;
				data_op_pkg::OFS_REF1: rdata_nxt = ref1_r;
				data_op_pkg::OFS_POWER: rdata_nxt = {31'h0000_0000, stop_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end else if (rvalid_r && s_axi_rready_i) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= '0;
			w_full_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= data_op_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= data_op_pkg::RESP_OKAY;
		end else begin
			aw_full_r <= aw_full_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_full_r <= w_full_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ****************************************************************
	// registers and operation sequencing
	// ****************************************************************
	// events raised by an evaluation cycle
	always_comb begin
		status_set = 3'h0;
		if (eval_r && !stop_r) begin
			case (op_sel)
				data_op_pkg::OP_COMPARE: status_set[data_op_pkg::STAT_DETECT_BIT] = detect_w;
				data_op_pkg::OP_ADD: status_set[data_op_pkg::STAT_OVF_BIT] = arith_wrap;
				data_op_pkg::OP_SUB: status_set[data_op_pkg::STAT_UNF_BIT] = arith_wrap;
				default: status_set = 3'h0;
			endcase
		end
	end

	// software writes, gated by module stop except the power register
	always_comb begin
		ctrl_nxt = ctrl_r;
		input_nxt = input_r;
		ref0_nxt = ref0_r;
		ref1_nxt = ref1_r;
		stop_nxt = stop_r;
		eval_nxt = 1'b0;
		status_clr = 3'h0;
		if (do_write && aw_addr_r == data_op_pkg::OFS_POWER && w_strb_r[0]) begin
			stop_nxt = w_data_r[data_op_pkg::POWER_STOP_BIT];
		end
		if (do_write && !stop_r) begin
			case (aw_addr_r)
				data_op_pkg::OFS_CTRL: ctrl_nxt = 8'(merge({24'h00_0000, ctrl_r}, w_data_r,
					w_strb_r)); // low byte only
				data_op_pkg::OFS_STATUS_CLEAR: if (w_strb_r[0]) begin
					status_clr = w_data_r[2:0];
				end
				data_op_pkg::OFS_INPUT: begin
					input_nxt = merge(input_r, w_data_r, w_strb_r);
					eval_nxt = 1'b1;
				end
				data_op_pkg::OFS_REF0: ref0_nxt = merge(ref0_r, w_data_r, w_strb_r);
				data_op_pkg::OFS_REF1: ref1_nxt = merge(ref1_r, w_data_r, w_strb_r);
				default: ctrl_nxt = ctrl_r;
			endcase
		end
		// sum or difference replaces reference 0
		if (eval_r && !stop_r && (op_sel == data_op_pkg::OP_ADD || op_sel == data_op_pkg::OP_SUB)) begin
			ref0_nxt = arith_result;
		end
		status_nxt = (status_r & ~status_clr) | status_set;
		event_nxt = |status_set;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			ctrl_r <= data_op_pkg::CTRL_RST;
			input_r <= data_op_pkg::DATA_RST;
			ref0_r <= data_op_pkg::DATA_RST;
			ref1_r <= data_op_pkg::DATA_RST;
			status_r <= data_op_pkg::STATUS_RST;
			stop_r <= data_op_pkg::STOP_RST;
			eval_r <= 1'b0;
			event_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			input_r <= input_nxt;
			ref0_r <= ref0_nxt;
			ref1_r <= ref1_nxt;
			status_r <= status_nxt;
			stop_r <= stop_nxt;
			eval_r <= eval_nxt;
			event_r <= event_nxt;
		end
	end

	// interrupt level gated by enable
	assign irq_o = ctrl_r[data_op_pkg::CTRL_IRQ_EN_BIT] && (|status_r);
	assign event_o = event_r;

	// ****************************************************************
	// assertions
	// ****************************************************************
	AST_EVAL_AFTER_INPUT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		do_write && !stop_r && aw_addr_r == data_op_pkg::OFS_INPUT |=> eval_r)
		else $error("input write did not start an evaluation");

	AST_DETECT_FLAG: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		eval_r && !stop_r && op_sel == data_op_pkg::OP_COMPARE && detect_w
		|=> status_r[data_op_pkg::STAT_DETECT_BIT] && event_o)
		else $error("detection not recorded");

	AST_OVF_FLAG: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		eval_r && !stop_r && op_sel == data_op_pkg::OP_ADD && arith_wrap
		|=> status_r[data_op_pkg::STAT_OVF_BIT])
		else $error("overflow not recorded");

	AST_UNF_FLAG: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		eval_r && !stop_r && op_sel == data_op_pkg::OP_SUB && arith_wrap
		|=> status_r[data_op_pkg::STAT_UNF_BIT])
		else $error("underflow not recorded");

	AST_EVENT_CAUSE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		event_o |-> $past(eval_r) && !$past(stop_r) && status_r != 3'h0)
		else $error("event pulse without an evaluation");

	AST_IRQ_GATE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(irq_o |-> ctrl_r[data_op_pkg::CTRL_IRQ_EN_BIT] && status_r != 3'h0) and
		(event_o |-> irq_o == ctrl_r[data_op_pkg::CTRL_IRQ_EN_BIT]))
		else $error("interrupt without enable or status");

	AST_STOP_HOLD: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		stop_r && $past(stop_r) |-> !eval_r && !event_o && $stable(input_r))
		else $error("activity during module stop");

	AST_ACCUM_RESULT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		eval_r && !stop_r && op_sel == data_op_pkg::OP_ADD |=> ref0_r == $past(arith_result))
		else $error("sum not written to reference 0");

	AST_CLEAR_BIT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		status_clr[data_op_pkg::STAT_DETECT_BIT] && !status_set[data_op_pkg::STAT_DETECT_BIT]
		|=> !status_r[data_op_pkg::STAT_DETECT_BIT])
		else $error("status clear ignored");
endmodule

// File: hw/data_op_pkg.sv
package data_op_pkg;

	// ****************************************************************
	// bus geometry and register map
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_STATUS_CLEAR = 8'h08;
	localparam logic [7:0] OFS_INPUT = 8'h0C;
	localparam logic [7:0] OFS_REF0 = 8'h10;
	localparam logic [7:0] OFS_REF1 = 8'h14;
	localparam logic [7:0] OFS_POWER = 8'h18;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_SIZE_BIT = 3;
	localparam int CTRL_DETECT_CONDITION_SELECT_LSB = 4;
	localparam int CTRL_IRQ_EN_BIT = 7;
	localparam int STAT_DETECT_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam int STAT_UNF_BIT = 2;
	localparam int POWER_STOP_BIT = 0;

	// ****************************************************************
	// operation and detection codes
	// ****************************************************************
	localparam logic [1:0] OP_COMPARE = 2'h0;
	localparam logic [1:0] OP_ADD = 2'h1;
	localparam logic [1:0] OP_SUB = 2'h2;
	localparam logic [2:0] DET_MISMATCH = 3'h0;
	localparam logic [2:0] DET_MATCH = 3'h1;
	localparam logic [2:0] DET_LESS = 3'h2;
	localparam logic [2:0] DET_GREATER = 3'h3;
	localparam logic [2:0] DET_IN_RANGE = 3'h4;
	localparam logic [2:0] DET_OUT_RANGE = 3'h5;

	// ****************************************************************
	// reset values and responses
	// ****************************************************************
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic STOP_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hw/data_op_compare.sv
`timescale 1ns/100ps
module data_op_compare #(
	parameter int DATA_W = 32
) (
	input wire logic [DATA_W-1:0] operand_i,
	input wire logic [DATA_W-1:0] ref0_i,
	input wire logic [DATA_W-1:0] ref1_i,
	input wire logic size_32_i,
	input wire logic [2:0] detect_sel_i,
	output logic detect_o
);
	localparam int HALF = DATA_W / 2;

	// ****************************************************************
	// width check
	// ****************************************************************
	if (DATA_W < 2 || DATA_W % 2 != 0) begin : g_bad_width
		$error("data_op_compare: DATA_W must be even and at least 2");
	end

	logic [DATA_W-1:0] mask;
	logic [DATA_W-1:0] a;
	logic [DATA_W-1:0] r0;
	logic [DATA_W-1:0] r1;

	// narrow mode keeps only the low half
	assign mask = size_32_i ? {DATA_W{1'b1}} : {{(DATA_W-HALF){1'b0}}, {HALF{1'b1}}};
	assign a = operand_i & mask;
	assign r0 = ref0_i & mask;
	assign r1 = ref1_i & mask;

	// condition decode, unsigned
	always_comb begin
		case (detect_sel_i)
			data_op_pkg::DET_MISMATCH: detect_o = (a != r0);
			data_op_pkg::DET_MATCH: detect_o = (a == r0);
			data_op_pkg::DET_LESS: detect_o = (a < r0);
			data_op_pkg::DET_GREATER: detect_o = (a > r0);
			data_op_pkg::DET_IN_RANGE: detect_o = (a > r0) && (a < r1);
			data_op_pkg::DET_OUT_RANGE: detect_o = (a < r0) || (a > r1);
			default: detect_o = 1'b0; // prohibited codes never detect
		endcase
	end
endmodule

// File: hw/data_op_arith.sv
`timescale 1ns/100ps
module data_op_arith #(
	parameter int DATA_W = 32
) (
	input wire logic [DATA_W-1:0] operand_i,
	input wire logic [DATA_W-1:0] accum_i,
	input wire logic size_32_i,
	input wire logic subtract_i,
	output logic [DATA_W-1:0] result_o,
	output logic wrap_o
);
	localparam int HALF = DATA_W / 2;

	// ****************************************************************
	// width check
	// ****************************************************************
	if (DATA_W < 2 || DATA_W % 2 != 0) begin : g_bad_width
		$error("data_op_arith: DATA_W must be even and at least 2");
	end

	logic [DATA_W-1:0] mask;
	logic [DATA_W:0] sum;
	logic [DATA_W:0] diff;

	// accumulator plus or minus operand, one bit wider for carry
	assign mask = size_32_i ? {DATA_W{1'b1}} : {{(DATA_W-HALF){1'b0}}, {HALF{1'b1}}};
	assign sum = {1'b0, accum_i & mask} + {1'b0, operand_i & mask};
	assign diff = {1'b0, accum_i & mask} - {1'b0, operand_i & mask};

	// carry out of the active width, borrow out of the top
	always_comb begin
		if (subtract_i) begin
			result_o = diff[DATA_W-1:0] & mask;
			wrap_o = diff[DATA_W];
		end else begin
			result_o = sum[DATA_W-1:0] & mask;
			wrap_o = size_32_i ? sum[DATA_W] : sum[HALF];
		end
	end
endmodule

// File: tb/data_op_unit_test.sv
`timescale 1ns/100ps
module data_op_unit_test;

	// ****************************************************************
	// clock, reset, bus signals and device
	// ****************************************************************
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irq, evt;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int errors = 0;
	int checks_done = 0;
	int ev_count = 0;

	always #10 clk_sys_i = ~clk_sys_i;

	// count event pulses, one per high cycle
	always @(posedge clk_sys_i) begin
		if (evt === 1'b1) ev_count <= ev_count + 1;
	end

	data_op_unit data_op_unit_i (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready),
		.s_axi_awaddr_i(awaddr),
		.s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready),
		.s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb),
		.s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready),
		.s_axi_bresp_o(bresp),
		.s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr),
		.s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready),
		.s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp),
		.irq_o(irq),
		.event_o(evt)
	);

	// ****************************************************************
	// reporting
	// ****************************************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// ****************************************************************
	// bus master: sample ready on the falling edge, release on the next rise
	// ****************************************************************
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		logic at, wt, ad, wd, bd;
		ad = 1'b0;
		wd = 1'b0;
		bd = 1'b0;
		@(posedge clk_sys_i);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		for (n = 0; n < 50 && !(ad && wd); n++) begin
			@(negedge clk_sys_i);
			at = awvalid & awready;
			wt = wvalid & wready;
			@(posedge clk_sys_i);
			if (at) awvalid <= 1'b0;
			if (at) ad = 1'b1;
			if (wt) wvalid <= 1'b0;
			if (wt) wd = 1'b1;
		end
		bready <= 1'b1;
		for (n = 0; n < 50 && !bd; n++) begin
			@(negedge clk_sys_i);
			bd = (bvalid === 1'b1);
			resp = bresp;
			@(posedge clk_sys_i);
		end
		bready <= 1'b0;
		if (!bd) begin
			errors++;
			end_of_test();
		end
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		logic t, rd;
		t = 1'b0;
		rd = 1'b0;
		@(posedge clk_sys_i);
		arvalid <= 1'b1;
		araddr <= a;
		for (n = 0; n < 50 && !t; n++) begin
			@(negedge clk_sys_i);
			t = arvalid & arready;
			@(posedge clk_sys_i);
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		for (n = 0; n < 50 && !rd; n++) begin
			@(negedge clk_sys_i);
			rd = (rvalid === 1'b1);
			d = rdata;
			resp = rresp;
			@(posedge clk_sys_i);
		end
		rready <= 1'b0;
		if (!(t && rd)) begin
			errors++;
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		check("write response", {30'h0, r}, {30'h0, data_op_pkg::RESP_OKAY});
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		check(what, d, exp);
		check("read response", {30'h0, r}, {30'h0, data_op_pkg::RESP_OKAY});
	endtask

	// ****************************************************************
	// one operation: set up, feed the input, judge status, event, irq, ref0
	// ****************************************************************
	task automatic run_op(input logic [7:0] ctrl, input logic [31:0] r0, input logic [31:0] r1,
			input logic [31:0] din, input logic [2:0] exp_st, input logic [31:0] exp_r0);
		int ev0;
		wr(data_op_pkg::OFS_STATUS_CLEAR, 32'h0000_0007);
		wr(data_op_pkg::OFS_CTRL, {24'h0, ctrl});
		wr(data_op_pkg::OFS_REF0, r0);
		wr(data_op_pkg::OFS_REF1, r1);
		ev0 = ev_count;
		wr(data_op_pkg::OFS_INPUT, din);
		repeat (3) @(posedge clk_sys_i);
		rd_chk("status", data_op_pkg::OFS_STATUS, {29'h0, exp_st});
		check("event count", ev_count - ev0, (exp_st != 3'h0) ? 1 : 0);
		check("irq", {31'h0, irq}, {31'h0, ctrl[7] && exp_st != 3'h0});
		rd_chk("ref0", data_op_pkg::OFS_REF0, exp_r0);
	endtask

	// expected detection, unsigned, on the selected width
	function automatic logic exp_det(input logic [2:0] c, input logic s32, input logic [31:0] d,
			input logic [31:0] a, input logic [31:0] b);
		logic [31:0] m;
		m = s32 ? 32'hFFFF_FFFF : 32'h0000_FFFF;
		d = d & m;
		a = a & m;
		b = b & m;
		case (c)
			3'h0: return d != a;
			3'h1: return d == a;
			3'h2: return d < a;
			3'h3: return d > a;
			3'h4: return (d > a) && (d < b);
			3'h5: return (d < a) || (d > b);
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic test_reset();
		rd_chk("ctrl", data_op_pkg::OFS_CTRL, {24'h0, data_op_pkg::CTRL_RST});
		rd_chk("status", data_op_pkg::OFS_STATUS, {29'h0, data_op_pkg::STATUS_RST});
		rd_chk("input", data_op_pkg::OFS_INPUT, data_op_pkg::DATA_RST);
		rd_chk("ref0", data_op_pkg::OFS_REF0, data_op_pkg::DATA_RST);
		rd_chk("ref1", data_op_pkg::OFS_REF1, data_op_pkg::DATA_RST);
		rd_chk("stop", data_op_pkg::OFS_POWER, {31'h0, data_op_pkg::STOP_RST});
		check("irq", {31'h0, irq}, 32'h0000_0000);
		wr(data_op_pkg::OFS_INPUT, 32'hFEDC_BA98);
		rd_chk("input", data_op_pkg::OFS_INPUT, 32'hFEDC_BA98);
		wstrb <= 4'h3;
		wr(data_op_pkg::OFS_INPUT, 32'h0000_1234);
		wstrb <= 4'hF;
		rd_chk("input lanes", data_op_pkg::OFS_INPUT, 32'hFEDC_1234);
		$display("test reset done");
	endtask

	task automatic test_compare();
		logic [31:0] hd, h0, h1, d;
		for (int s = 0; s < 2; s++) begin
			hd = (s == 0) ? 32'h1234_0000 : 32'h0000_0000;
			h0 = (s == 0) ? 32'hA5A5_0000 : 32'h0000_0000;
			h1 = (s == 0) ? 32'h5A5A_0000 : 32'h0000_0000;
			for (int c = 0; c < 8; c++) begin
				for (int v = 1; v < 6; v++) begin
					d = hd | (32'h0000_0032 * v);
					run_op({1'b0, c[2:0], s[0], 3'h0}, h0 | 32'h0000_0064, h1 | 32'h0000_00C8, d,
						{2'h0, exp_det(c[2:0], s[0], d, h0 | 32'h0000_0064, h1 | 32'h0000_00C8)},
						h0 | 32'h0000_0064);
				end
			end
		end
		$display("test compare done");
	endtask

	task automatic test_arith();
		run_op(8'h01, 32'h0000_FFFF, 32'h0, 32'h0000_0001, 3'h2, 32'h0000_0000);
		run_op(8'h81, 32'hABCD_FFFE, 32'h0, 32'h1111_0001, 3'h0, 32'h0000_FFFF);
		run_op(8'h89, 32'hFFFF_FFFF, 32'h0, 32'h0000_0001, 3'h2, 32'h0000_0000);
		run_op(8'h09, 32'h0000_FFFF, 32'h0, 32'h0000_0001, 3'h0, 32'h0001_0000);
		run_op(8'h02, 32'h0000_0000, 32'h0, 32'h0000_0001, 3'h4, 32'h0000_FFFF);
		run_op(8'h02, 32'h0000_0005, 32'h0, 32'h0000_0005, 3'h0, 32'h0000_0000);
		run_op(8'h8A, 32'h0000_0000, 32'h0, 32'h0000_0001, 3'h4, 32'hFFFF_FFFF);
		run_op(8'h0A, 32'h0001_0000, 32'h0, 32'h0000_0001, 3'h0, 32'h0000_FFFF);
		run_op(8'h03, 32'h0000_0000, 32'h0, 32'h0000_0001, 3'h0, 32'h0000_0000);
		$display("test arith done");
	endtask

	task automatic test_irq();
		run_op(8'h90, 32'h0000_0007, 32'h0, 32'h0000_0007, 3'h1, 32'h0000_0007);
		wr(data_op_pkg::OFS_STATUS, 32'h0000_0000);
		rd_chk("status kept", data_op_pkg::OFS_STATUS, 32'h0000_0001);
		wr(data_op_pkg::OFS_STATUS_CLEAR, 32'h0000_0002);
		rd_chk("status kept", data_op_pkg::OFS_STATUS, 32'h0000_0001);
		rd_chk("clear reads", data_op_pkg::OFS_STATUS_CLEAR, 32'h0000_0000);
		wr(data_op_pkg::OFS_STATUS_CLEAR, 32'h0000_0001);
		rd_chk("status clear", data_op_pkg::OFS_STATUS, 32'h0000_0000);
		check("irq off", {31'h0, irq}, 32'h0000_0000);
		run_op(8'h10, 32'h0000_0007, 32'h0, 32'h0000_0007, 3'h1, 32'h0000_0007);
		wr(data_op_pkg::OFS_CTRL, 32'h0000_0090);
		check("irq enable", {31'h0, irq}, 32'h0000_0001);
		wr(data_op_pkg::OFS_CTRL, 32'hFFFF_FFFF);
		rd_chk("ctrl width", data_op_pkg::OFS_CTRL, 32'h0000_00FF);
		$display("test irq done");
	endtask

	task automatic test_stop_map();
		logic [31:0] d;
		logic [1:0] r;
		int ev0;
		run_op(8'h10, 32'h0000_0005, 32'h0, 32'h0000_0006, 3'h0, 32'h0000_0005);
		wr(data_op_pkg::OFS_POWER, 32'h0000_0001);
		ev0 = ev_count;
		wr(data_op_pkg::OFS_INPUT, 32'h0000_0005);
		wr(data_op_pkg::OFS_CTRL, 32'h0000_0000);
		repeat (3) @(posedge clk_sys_i);
		rd_chk("stop status", data_op_pkg::OFS_STATUS, 32'h0000_0000);
		check("stop event", ev_count - ev0, 0);
		rd_chk("stop ctrl", data_op_pkg::OFS_CTRL, 32'h0000_0010);
		rd_chk("stop power", data_op_pkg::OFS_POWER, 32'h0000_0001);
		wr(data_op_pkg::OFS_POWER, 32'h0000_0000);
		run_op(8'h10, 32'h0000_0005, 32'h0, 32'h0000_0005, 3'h1, 32'h0000_0005);
		axi_read(8'h1C, d, r);
		check("unmapped read", d, 32'h0000_0000);
		check("unmapped resp", {30'h0, r}, {30'h0, data_op_pkg::RESP_SLVERR});
		axi_write(8'h1C, 32'hFFFF_FFFF, r);
		check("unmapped wresp", {30'h0, r}, {30'h0, data_op_pkg::RESP_SLVERR});
		$display("test stop and map done");
	endtask

	initial begin
		repeat (4) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		test_reset();
		test_compare();
		test_arith();
		test_irq();
		test_stop_map();
		end_of_test();
	end

endmodule
